// file: src/spra_pkg.sv
// Shared constants and types for the sector protection map access block
package spra_pkg;

  localparam int          MAP_BYTES      = 8;
  localparam int          SPEC_BITS      = 9;
  localparam int          READ_BITS      = 64;
  localparam int          DUMMY_BYTES    = 3;
  localparam int          CLK_PERIOD_NS  = 100;

  localparam logic [7:0]  OPC_PREFIX0    = 8'h3D;
  localparam logic [7:0]  OPC_PREFIX1    = 8'h2A;
  localparam logic [7:0]  OPC_PREFIX2    = 8'h7F;
  localparam logic [7:0]  OPC_ERASE_MAP  = 8'hCF;
  localparam logic [7:0]  OPC_PROG_MAP   = 8'hFC;
  localparam logic [7:0]  OPC_READ_MAP   = 8'h32;

  localparam logic [7:0]  BYTE_ERASED    = 8'hFF;
  localparam logic [7:0]  BYTE_FACTORY   = 8'h00;
  localparam logic [1:0]  PAIR_PROTECTED = 2'h3;
  localparam int          SUB0A_HI       = 7;
  localparam int          SUB0A_LO       = 6;
  localparam int          SUB0B_HI       = 5;
  localparam int          SUB0B_LO       = 4;

  localparam logic [6:0]  READ_LAST      = 7'h40;
  localparam logic [1:0]  DUMMY_LAST     = 2'h2;
  localparam logic [2:0]  BIT_LAST       = 3'h7;

  typedef struct packed {
    logic csN;
    logic sck;
    logic si;
    logic wpN;
  } spra_pins_type;

  typedef enum logic {
    JOB_ERASE,
    JOB_PROGRAM
  } spra_job_type;

  // Protection spec from the map: bit0 sub 0a, bit1 sub 0b, bits 2..8 sectors 1..7
  function automatic logic [SPEC_BITS-1:0] spra_decode_spec(
    input logic [MAP_BYTES*8-1:0] map
  );
    logic [SPEC_BITS-1:0] spec;
    spec    = '0;
    spec[0] = map[SUB0A_HI:SUB0A_LO] == PAIR_PROTECTED;
    spec[1] = map[SUB0B_HI:SUB0B_LO] == PAIR_PROTECTED;
    for (int n = 1; n < MAP_BYTES; n++) begin
      spec[n+1] = map[n*8 +: 8] == BYTE_ERASED;
    end
    return spec;
  endfunction

endpackage

// file: src/spra_sync.sv
// Two-flop synchroniser for the serial pins
`timescale 1ns/100ps
`default_nettype none
module spra_sync
  import spra_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire spra_pins_type pinsIn,
  output var  spra_pins_type pinsOut
);

  spra_pins_type meta_q;

  // Idle pin levels: chip select and write protect released, clock low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q  <= '{csN: 1'b1, sck: 1'b0, si: 1'b0, wpN: 1'b1};
      pinsOut <= '{csN: 1'b1, sck: 1'b0, si: 1'b0, wpN: 1'b1};
    end else begin
      meta_q  <= pinsIn;
      pinsOut <= meta_q;
    end
  end

endmodule
`default_nettype wire

// file: src/spra_timer.sv
// Self-timed cycle counter with busy level and done pulse
`timescale 1ns/100ps
`default_nettype none
module spra_timer
  import spra_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [31:0] loadCycles,
  output logic             busy,
  output logic             done
);

  logic [31:0] count_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        count_q <= loadCycles;
        busy    <= 1'b1;
      end else if (busy) begin
        count_q <= count_q - 32'h0000_0001;
        if (count_q == 32'h0000_0001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: src/spra_core.sv
// Serial access to the nonvolatile sector protection map: erase, program, read
//
// Notes on behaviour
// - Eight-byte map, byte n selects protection of sector n.
// - Sectors 1..7: FF means protected, 00 unprotected.
// - Sector 0: bits 7:6 govern 0a, 5:4 govern 0b; 11 protects.
// - Map accepts new contents only after an erase.
// - Opcodes 3D 2A 7F CF then chip select release start erase.
// - Busy is reported for the whole self-timed erase.
// - Erase sets every map byte to FF.
// - Erase runs whether sector protection is enabled or not.
// - Opcodes 3D 2A 7F FC then eight bytes, sector 0 first.
// - Release after data starts self-timed program, busy throughout.
// - Bytes beyond eight wrap the write index to zero.
// - Program is accepted whether protection is enabled or not.
// - Program uses buffer 1 as working storage, clobbering it.
// - Opcode 32 plus three dummy bytes, then bytes 0..7 out.
// - After byte 7, further clocks give undefined output; the code drives the line low.
// - Chip select release ends the read, output goes high impedance.
// - Factory contents are all zeros, nothing protected.
// - Write protect asserted refuses map erase and program.
// - Marked sectors are blocked only while protection is enabled.
`timescale 1ns/100ps
`default_nettype none
module spra_core
  import spra_pkg::*;
#(
  parameter int PROTECT_MAP_ERASE_TIME_NS = 2_000_000,
  parameter int PROGRAM_CYCLE_TIME_NS     = 2_000_000
)(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 csN,
  input  wire logic                 sck,
  input  wire logic                 si,
  input  wire logic                 wpN,
  input  wire logic                 protectCmdEnabled,
  output logic                      soOut,
  output logic                      soOe,
  output logic                      busy,
  output logic                      buf1Clobber,
  output logic [SPEC_BITS-1:0]      sectorBlocked
);

  // Longest times round down, never below one cycle
  localparam int ERASE_CYCLES_RAW = PROTECT_MAP_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int PROG_CYCLES_RAW  = PROGRAM_CYCLE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [31:0] ERASE_CYCLES = 32'(ERASE_CYCLES_RAW < 1 ? 1 : ERASE_CYCLES_RAW);
  localparam logic [31:0] PROG_CYCLES  = 32'(PROG_CYCLES_RAW < 1 ? 1 : PROG_CYCLES_RAW);

  typedef enum logic [3:0] {
    ST_OP0,
    ST_OP1,
    ST_OP2,
    ST_OP3,
    ST_DUMMY,
    ST_RDATA,
    ST_PDATA,
    ST_ERASE_ARMED,
    ST_IGNORE
  } spra_state_type;

  spra_pins_type        pinsRaw;
  spra_pins_type        pinsSync;
  spra_state_type       state_q;
  spra_state_type       state_d;
  spra_job_type         job_q;
  logic                 sckPrev_q;
  logic                 csPrev_q;
  logic [7:0]           shift_q;
  logic [2:0]           bitCnt_q;
  logic [1:0]           dummyCnt_q;
  logic [2:0]           writeIdx_q;
  logic                 gotData_q;
  logic [6:0]           readBit_q;
  logic [7:0]           map_q   [MAP_BYTES];
  logic [7:0]           stage_q [MAP_BYTES];
  logic                 timerStart_q;
  logic [31:0]          timerLoad_q;
  logic                 timerBusy;
  logic                 timerDone;

  wire logic       sckRise     = pinsSync.sck && !sckPrev_q;
  wire logic       sckFall     = !pinsSync.sck && sckPrev_q;
  wire logic       csActive    = !pinsSync.csN;
  wire logic       csFall      = !pinsSync.csN && csPrev_q;
  wire logic       csRise      = pinsSync.csN && !csPrev_q;
  wire logic       wpAsserted  = !pinsSync.wpN;
  wire logic [7:0] byteIn      = {shift_q[6:0], pinsSync.si};
  wire logic       byteDone    = csActive && sckRise && (bitCnt_q == BIT_LAST);
  wire logic       readActive  = csActive && (state_q == ST_RDATA);
  wire logic       readInRange = readBit_q < READ_LAST;
  wire logic [2:0] readByte    = readBit_q[5:3];
  wire logic [2:0] readBitPos  = BIT_LAST - readBit_q[2:0];
  wire logic       eraseGo     = csRise && (state_q == ST_ERASE_ARMED) && !wpAsserted;
  wire logic       progGo      = csRise && (state_q == ST_PDATA) && gotData_q && !wpAsserted;
  wire logic       protEnabled = protectCmdEnabled || wpAsserted;

  logic [MAP_BYTES*8-1:0] mapFlat;
  always_comb begin
    for (int n = 0; n < MAP_BYTES; n++) begin
      mapFlat[n*8 +: 8] = map_q[n];
    end
  end

  assign pinsRaw = '{csN: csN, sck: sck, si: si, wpN: wpN};

  spra_sync u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pinsIn  (pinsRaw),
    .pinsOut (pinsSync)
  );

  spra_timer u_timer (
    .clk        (clk),
    .rst_n      (rst_n),
    .start      (timerStart_q),
    .loadCycles (timerLoad_q),
    .busy       (timerBusy),
    .done       (timerDone)
  );

  // Command byte sequencing
  always_comb begin
    state_d = state_q;
    if (csFall) begin
      // Commands arriving during a self-timed cycle are dropped
      state_d = (timerBusy || busy) ? ST_IGNORE : ST_OP0;
    end else if (!csActive) begin
      state_d = ST_OP0;
    end else if (byteDone) begin
      case (state_q)
        ST_OP0: begin
          if (byteIn == OPC_PREFIX0) begin
            state_d = ST_OP1;
          end else if (byteIn == OPC_READ_MAP) begin
            state_d = ST_DUMMY;
          end else begin
            state_d = ST_IGNORE;
          end
        end
        ST_OP1: begin
          state_d = (byteIn == OPC_PREFIX1) ? ST_OP2 : ST_IGNORE;
        end
        ST_OP2: begin
          state_d = (byteIn == OPC_PREFIX2) ? ST_OP3 : ST_IGNORE;
        end
        // final opcode byte selects erase or program
        ST_OP3: begin
          if (byteIn == OPC_ERASE_MAP) begin
            state_d = ST_ERASE_ARMED;
          end else if (byteIn == OPC_PROG_MAP) begin
            state_d = ST_PDATA;
          end else begin
            state_d = ST_IGNORE;
          end
        end
        ST_DUMMY: begin
          if (dummyCnt_q == DUMMY_LAST) begin
            state_d = ST_RDATA;
          end
        end
        // A whole trailing byte after the erase opcode voids the command
        ST_ERASE_ARMED: begin
          state_d = ST_IGNORE;
        end
        ST_RDATA,
        ST_PDATA,
        ST_IGNORE: begin
          state_d = state_q;
        end
        default: begin
          state_d = ST_IGNORE;
        end
      endcase
    end
  end

  // Serial input shifter, reset at every frame start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sckPrev_q <= 1'b0;
      csPrev_q  <= 1'b1;
      shift_q   <= '0;
      bitCnt_q  <= '0;
      state_q   <= ST_OP0;
    end else begin
      sckPrev_q <= pinsSync.sck;
      csPrev_q  <= pinsSync.csN;
      state_q   <= state_d;
      if (!csActive) begin
        bitCnt_q <= '0;
      end else if (sckRise) begin
        shift_q  <= byteIn;
        bitCnt_q <= bitCnt_q + 3'h1;
      end
    end
  end

  // Dummy byte and program write index counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dummyCnt_q <= '0;
      writeIdx_q <= '0;
      gotData_q  <= 1'b0;
    end else if (!csActive) begin
      dummyCnt_q <= '0;
      writeIdx_q <= '0;
      gotData_q  <= 1'b0;
    end else if (byteDone && state_q == ST_DUMMY) begin
      dummyCnt_q <= dummyCnt_q + 2'h1;
    end else if (byteDone && state_q == ST_PDATA) begin
      // index wraps after the eighth byte
      writeIdx_q <= writeIdx_q + 3'h1;
      gotData_q  <= 1'b1;
    end
  end

  // staging array stands for buffer 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int n = 0; n < MAP_BYTES; n++) begin
        stage_q[n] <= BYTE_ERASED;
      end
    end else if (byteDone && state_q == ST_OP3 && byteIn == OPC_PROG_MAP) begin
      // Unsent bytes keep the erased pattern so they leave the map as is
      for (int n = 0; n < MAP_BYTES; n++) begin
        stage_q[n] <= BYTE_ERASED;
      end
    end else if (byteDone && state_q == ST_PDATA) begin
      // first data byte lands at sector 0
      stage_q[writeIdx_q] <= byteIn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf1Clobber <= 1'b0;
    end else begin
      // buffer 1 content is lost when program opcode lands
      buf1Clobber <= byteDone && state_q == ST_OP3 && byteIn == OPC_PROG_MAP;
    end
  end

  // Self-timed job launch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timerStart_q <= 1'b0;
      timerLoad_q  <= '0;
      job_q        <= JOB_ERASE;
    end else begin
      timerStart_q <= 1'b0;
      if (eraseGo) begin
        timerStart_q <= 1'b1;
        timerLoad_q  <= ERASE_CYCLES;
        job_q        <= JOB_ERASE;
      end else if (progGo) begin
        timerStart_q <= 1'b1;
        timerLoad_q  <= PROG_CYCLES;
        job_q        <= JOB_PROGRAM;
      end
    end
  end

  // Busy covers the launch cycle too, so status never shows a gap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= eraseGo || progGo || timerStart_q || (timerBusy && !timerDone);
    end
  end

  // map held in flops, factory value at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int n = 0; n < MAP_BYTES; n++) begin
        map_q[n] <= BYTE_FACTORY;
      end
    end else if (timerDone && job_q == JOB_ERASE) begin
      // erase sets all bytes to FF
      for (int n = 0; n < MAP_BYTES; n++) begin
        map_q[n] <= BYTE_ERASED;
      end
    end else if (timerDone && job_q == JOB_PROGRAM) begin
      // programming only clears bits, so erase must come first
      for (int n = 0; n < MAP_BYTES; n++) begin
        map_q[n] <= map_q[n] & stage_q[n];
      end
    end
  end

  // Read data shifted out on falling clock edges, MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readBit_q <= '0;
      soOut     <= 1'b0;
      soOe      <= 1'b0;
    end else if (!readActive) begin
      // released select ends the read, output floats
      readBit_q <= '0;
      soOut     <= 1'b0;
      soOe      <= 1'b0;
    end else if (sckFall) begin
      soOe <= 1'b1;
      if (readInRange) begin
        // sector 0 first, sector 7 last
        soOut     <= map_q[readByte][readBitPos];
        readBit_q <= readBit_q + 7'h01;
      end else begin
        // beyond byte 7 the line reads low
        soOut <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sectorBlocked <= '0;
    end else begin
      sectorBlocked <= protEnabled ? spra_decode_spec(mapFlat) : '0;
    end
  end

endmodule
`default_nettype wire

// file: tb/spra_core_asserts.sv
// Concurrent checks on the sector protection map access ports
`timescale 1ns/100ps
`default_nettype none
module spra_core_asserts
  import spra_pkg::*;
#(
  parameter int PROTECT_MAP_ERASE_TIME_NS = 2_000_000,
  parameter int PROGRAM_CYCLE_TIME_NS     = 2_000_000
)(
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 csN,
  input wire logic                 sck,
  input wire logic                 si,
  input wire logic                 wpN,
  input wire logic                 protectCmdEnabled,
  input wire logic                 soOut,
  input wire logic                 soOe,
  input wire logic                 busy,
  input wire logic                 buf1Clobber,
  input wire logic [SPEC_BITS-1:0] sectorBlocked
);
  localparam int EraseCycles = PROTECT_MAP_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int ProgCycles  = PROGRAM_CYCLE_TIME_NS / CLK_PERIOD_NS;
  localparam int MinCycles   = (EraseCycles < ProgCycles) ? EraseCycles : ProgCycles;
  // Slack covers the timer's extra cycles
  localparam int MaxCycles   = ((EraseCycles > ProgCycles) ? EraseCycles : ProgCycles) + 6;

  int busyLen_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busyLen_q <= 0;
    end else begin
      busyLen_q <= busy ? busyLen_q + 1 : 0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_busy_start: assert property ($rose(busy) |-> csN && $past(csN, 2))
    else $error("busy rose inside a frame");
  a_busy_floor: assert property ($fell(busy) |-> busyLen_q >= MinCycles)
    else $error("self-timed cycle ended early");
  a_busy_ceiling: assert property (busy |-> busyLen_q <= MaxCycles)
    else $error("self-timed cycle too long");
  a_wp_no_busy: assert property ($rose(busy) |-> wpN && $past(wpN, 4))
    else $error("cycle started with write protect low");
  a_oe_ends: assert property (csN [*6] |-> !soOe)
    else $error("output driven without chip select");
  a_oe_frame: assert property ($rose(soOe) |-> !csN && !busy)
    else $error("output enabled outside a read");
  a_so_idle_low: assert property (!soOe |-> !soOut)
    else $error("serial output high while released");
  a_clobber_pulse: assert property (buf1Clobber |=> !buf1Clobber)
    else $error("buffer clobber pulse too long");
  a_clobber_frame: assert property (buf1Clobber |-> !csN && !$past(csN, 3))
    else $error("buffer clobber outside a frame");
  a_blocked_off: assert property ((!protectCmdEnabled && wpN) [*5] |-> sectorBlocked == '0)
    else $error("sector blocked while protection off");

  cover property ($fell(busy));
  cover property ($rose(soOe));
  cover property (buf1Clobber);
  cover property (sectorBlocked == '1);
endmodule

bind spra_core spra_core_asserts #(
  .PROTECT_MAP_ERASE_TIME_NS(PROTECT_MAP_ERASE_TIME_NS),
  .PROGRAM_CYCLE_TIME_NS    (PROGRAM_CYCLE_TIME_NS)
) u_spra_core_asserts (
  .clk(clk), .rst_n(rst_n), .csN(csN), .sck(sck), .si(si), .wpN(wpN),
  .protectCmdEnabled(protectCmdEnabled), .soOut(soOut), .soOe(soOe), .busy(busy),
  .buf1Clobber(buf1Clobber), .sectorBlocked(sectorBlocked)
);
`default_nettype wire

// file: tb/spra_host_model.sv
// Host serial master model, mode 0, one bit per eight clocks
`timescale 1ns/100ps
`default_nettype none
module spra_host_model (
  input  wire logic clk,
  input  wire logic busy,
  input  wire logic soLine,
  output var  logic csN,
  output var  logic sck,
  output var  logic si
);
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si  = 1'b0;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      si  <= tx[i];
      ticks(4);
      sck <= 1'b1;
      ticks(4);
      rx[i] = soLine;
    end
  endtask

  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] r;
    rx = {};
    csN <= 1'b0;
    ticks(4);
    foreach (tx[k]) begin
      xfer(tx[k], r);
      rx.push_back(r);
    end
    sck <= 1'b0;
    ticks(4);
    csN <= 1'b1;
    ticks(6);
  endtask

  task automatic waitIdle(output logic ok);
    ok = 1'b0;
    for (int k = 0; k < 200 && !ok; k++) begin
      ticks(1);
      ok = (busy === 1'b0);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/test_sector_protect_register_access.sv
// Self-checking bench for the sector protection map access block
`timescale 1ns/100ps
`default_nettype none
module test_sector_protect_register_access;
  import spra_pkg::*;

  logic                 clk;
  logic                 rst_n;
  logic                 wpN;
  logic                 protectCmdEnabled;
  logic                 csN;
  logic                 sck;
  logic                 si;
  logic                 soOut;
  logic                 soOe;
  logic                 busy;
  logic                 buf1Clobber;
  logic [SPEC_BITS-1:0] sectorBlocked;
  wire logic            soLine;
  int                   n_errors;
  int                   n_tests;
  int                   nClobber;
  logic [7:0]           none[$];

  // Released line flips so a stale bit never reads as valid
  assign soLine = soOe ? soOut : ~soOut;

  spra_core #(.PROTECT_MAP_ERASE_TIME_NS(1000), .PROGRAM_CYCLE_TIME_NS(1000)) u_spra_core (
    .clk(clk), .rst_n(rst_n), .csN(csN), .sck(sck), .si(si), .wpN(wpN),
    .protectCmdEnabled(protectCmdEnabled), .soOut(soOut), .soOe(soOe), .busy(busy),
    .buf1Clobber(buf1Clobber), .sectorBlocked(sectorBlocked)
  );

  spra_host_model u_spra_host_model (
    .clk(clk), .busy(busy), .soLine(soLine), .csN(csN), .sck(sck), .si(si)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (buf1Clobber === 1'b1) nClobber++;
  end

  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic readMap(input logic [63:0] exp, input string msg);
    logic [7:0] tx[$];
    logic [7:0] rx[$];
    tx = {OPC_READ_MAP, 8'h00, 8'h00, 8'h00};
    repeat (MAP_BYTES + 1) tx.push_back(8'h00);
    u_spra_host_model.frame(tx, rx);
    for (int k = 0; k < MAP_BYTES; k++) begin
      check(rx[DUMMY_BYTES + 1 + k] === exp[63 - 8*k -: 8], msg);
    end
    check(rx[DUMMY_BYTES + 1 + MAP_BYTES] === 8'h00, "bits past the map not low");
    check(soOe === 1'b0, "output not released");
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] data[$], input logic expBusy);
    logic [7:0] tx[$];
    logic [7:0] rx[$];
    logic       ok;
    tx = {OPC_PREFIX0, OPC_PREFIX1, OPC_PREFIX2, op};
    foreach (data[k]) tx.push_back(data[k]);
    u_spra_host_model.frame(tx, rx);
    check(busy === expBusy, "busy after frame wrong");
    u_spra_host_model.waitIdle(ok);
    check(ok, "busy never cleared");
  endtask

  task automatic t_factory();
    protectCmdEnabled <= 1'b1;
    readMap(64'h0000_0000_0000_0000, "factory map not zero");
    check(sectorBlocked === 9'h000, "zero map blocks a sector");
  endtask

  task automatic t_wp_refuse();
    wpN <= 1'b0;
    cmd(OPC_ERASE_MAP, none, 1'b0);
    wpN <= 1'b1;
    // Trailing byte voids the erase, empty program is dropped
    cmd(OPC_ERASE_MAP, {8'h00}, 1'b0);
    cmd(OPC_PROG_MAP, none, 1'b0);
    readMap(64'h0000_0000_0000_0000, "erase ran under write protect");
  endtask

  task automatic t_erase();
    cmd(OPC_ERASE_MAP, none, 1'b1);
    readMap(64'hFFFF_FFFF_FFFF_FFFF, "erased map not all ones");
    check(sectorBlocked === 9'h1FF, "erased map not all blocked");
    protectCmdEnabled <= 1'b0;
    u_spra_host_model.ticks(3);
    check(sectorBlocked === 9'h000, "blocked with protection off");
  endtask

  task automatic t_program();
    int c0;
    protectCmdEnabled <= 1'b1;
    c0 = nClobber;
    // Ninth byte lands on sector 0
    cmd(OPC_PROG_MAP, {8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hC5}, 1'b1);
    check(nClobber === c0 + 1, "buffer clobber not seen once");
    readMap(64'hC5FF_00FF_0000_FF00, "programmed map wrong");
    check(sectorBlocked === 9'h095, "sector decode wrong");
  endtask

  task automatic t_no_erase();
    logic [7:0] ones[$];
    repeat (MAP_BYTES) ones.push_back(8'hFF);
    cmd(OPC_PROG_MAP, ones, 1'b1);
    readMap(64'hC5FF_00FF_0000_FF00, "map set without erase");
  endtask

  task automatic t_wp_enable();
    protectCmdEnabled <= 1'b0;
    wpN <= 1'b0;
    u_spra_host_model.ticks(5);
    check(sectorBlocked === 9'h095, "write protect did not enable");
    wpN <= 1'b1;
    u_spra_host_model.ticks(5);
    check(sectorBlocked === 9'h000, "protection stuck after pin high");
  endtask

  // Reset in mid-run cuts a running erase
  task automatic t_reset_mid();
    logic [7:0] tx[$];
    logic [7:0] rx[$];
    tx = {OPC_PREFIX0, OPC_PREFIX1, OPC_PREFIX2, OPC_ERASE_MAP};
    protectCmdEnabled <= 1'b1;
    u_spra_host_model.frame(tx, rx);
    check(busy === 1'b1, "erase not running before reset");
    check(sectorBlocked === 9'h095, "map decode lost before reset");
    rst_n <= 1'b0;
    u_spra_host_model.ticks(2);
    check({busy, soOe, buf1Clobber} === 3'h0, "outputs not cleared in reset");
    check(sectorBlocked === 9'h000, "blocked sectors kept in reset");
    rst_n <= 1'b1;
    u_spra_host_model.ticks(3);
    readMap(64'h0000_0000_0000_0000, "map not factory after reset");
  endtask

  task automatic test_done();
    $display("errors %0d, checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    // Whole run is near 8200 clocks
    repeat (40000) @(posedge clk);
    n_errors++;
    test_done();
  end

  initial begin
    n_errors          = 0;
    n_tests           = 0;
    nClobber          = 0;
    rst_n             = 1'b0;
    wpN               = 1'b1;
    protectCmdEnabled = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    u_spra_host_model.ticks(3);
    t_factory();
    t_wp_refuse();
    t_erase();
    t_program();
    t_no_erase();
    t_wp_enable();
    t_reset_mid();
    test_done();
  end
endmodule
`default_nettype wire
